/* serial_usart_pkg.sv */
// Register map, field positions and reset values of the serial transceiver.
package serial_usart_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [2:0] OFF_DATA   = 3'h0;
	localparam logic [2:0] OFF_STAT_A = 3'h1;
	localparam logic [2:0] OFF_CTRL_B = 3'h2;
	localparam logic [2:0] OFF_FMT_C  = 3'h3;
	localparam logic [2:0] OFF_BAUD_H = 3'h4;
	localparam logic [2:0] OFF_BAUD_L = 3'h5;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int A_TXC  = 6;
	localparam int A_U2X  = 1;
	localparam int A_MPCM = 0;
	localparam int B_RXCIE = 7;
	localparam int B_TXCIE = 6;
	localparam int B_UDRIE = 5;
	localparam int B_RXEN  = 4;
	localparam int B_TXEN  = 3;
	localparam int B_CSZH  = 2;
	localparam int B_TX8   = 0;
	localparam int C_SYNC  = 6;
	localparam int C_PARH  = 5;
	localparam int C_PARL  = 4;
	localparam int C_STOP2 = 3;
	localparam int C_CSZ1  = 2;
	localparam int C_CSZ0  = 1;
	localparam int C_POL   = 0;

	// ****************************************
	// Reset values and rate constants
	// ****************************************
	localparam logic [7:0]  CTRL_B_RST = 8'h00;
	localparam logic [6:0]  FMT_C_RST  = 7'h06;
	localparam logic [11:0] BAUD_RST   = 12'h000;
	localparam logic [3:0]  OS_NORMAL  = 4'hf;
	localparam logic [3:0]  OS_DOUBLE  = 4'h7;
	localparam logic [3:0]  HALF_NORMAL = 4'h7;
	localparam logic [3:0]  HALF_DOUBLE = 4'h3;

endpackage : serial_usart_pkg

/* serial_usart.sv */
// Serial transceiver: register file, baud prescaler, transmitter and receiver.
// Contract
// - Data writes fill the transmit buffer; reads give receive buffer, unused bits zero.
// - Data writes are dropped while the buffer-empty flag is clear.
// - Enabled transmitter moves buffer into idle shift register and sends it.
// - Receive buffer is a two-entry FIFO; each data read pops it.
// - Receive-complete flag shows unread data; receiver disable flushes and clears it.
// - Transmit-complete sets after frame with empty buffer; cleared by ack or one.
// - Buffer-empty flag reads one when buffer accepts data, and after reset.
// - Frame error shows stop bit of head character until it is read.
// - Overrun sets on full FIFO, waiting char and new start; held until read.
// - Double speed divides by 8 instead of 16 in asynchronous mode.
// - Multiprocessor filter drops frames that carry no address.
// - Each interrupt needs its enable, global enable and its flag.
// - Receiver owns its pin; disable flushes buffer and error flags.
// - Transmitter owns its pin; disable waits until shift and buffer empty.
// - Mode select: 0 asynchronous, 1 synchronous.
// - Parity field: off, reserved, even, odd; receiver flags mismatch.
// - Stop select gives one or two transmitted stop bits; receiver ignores it.
// - Size code 0 to 3 gives 5 to 8 bits, 7 gives 9.
// - Synchronous clock polarity picks change and sample edges.
// - Baud setting is 12 bits; low write reloads the prescaler.
// - Frame type is first stop bit, or ninth bit in 9-bit frames.
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module serial_usart (
	// Clock, reset and clock enable
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	input  wire logic       ce_i,
	// Register port
	input  wire logic [2:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rdata_o,
	// Interrupt requests
	input  wire logic       global_irq_enable_i,
	input  wire logic       tx_irq_ack_i,
	output logic            rx_irq_o,
	output logic            tx_irq_o,
	output logic            udre_irq_o,
	// Serial pins
	input  wire logic       serial_in_pin_i,
	output logic            serial_out_pin_o,
	output logic            serial_out_en_o,
	output logic            rx_pin_owned_o,
	output logic            serial_clock_pin_o,
	output logic            serial_clock_en_o
);

	typedef enum logic [5:0] {
		TX_IDLE  = 6'b000001,
		TX_START = 6'b000010,
		TX_DATA  = 6'b000100,
		TX_PAR   = 6'b001000,
		TX_STOP1 = 6'b010000,
		TX_STOP2 = 6'b100000
	} tx_state_t;

	typedef enum logic [4:0] {
		RX_IDLE  = 5'b00001,
		RX_START = 5'b00010,
		RX_DATA  = 5'b00100,
		RX_PAR   = 5'b01000,
		RX_STOP  = 5'b10000
	} rx_state_t;

	function automatic logic [3:0] char_bits(input logic [2:0] code);
		char_bits = (code == 3'h7) ? 4'h9 : (code[2] ? 4'h8 : 4'h5 + {2'h0, code[1:0]});
	endfunction : char_bits

	function automatic logic par_of(input logic [8:0] d, input logic odd);
		par_of = (^d) ^ odd;
	endfunction : par_of

	// ****************************************
	// Registers and decode
	// ****************************************
	logic [7:0]  ctrl_b_r;
	logic [6:0]  fmt_c_r;
	logic [11:0] baud_r;
	logic        double_speed_r, multiproc_filter_r, tx_complete_flag_r, overrun_flag_r;
	logic [8:0]  transmit_buffer_r;
	logic        tbuf_v_r;
	logic [11:0] fifo_r [2];
	logic [1:0]  fifo_cnt_r;
	logic [11:0] wait_r;
	logic        wait_v_r;
	logic [11:0] presc_r;
	logic        xck_r;
	logic        tx_owned_r;

	wire wr_data = wr_i && addr_i == serial_usart_pkg::OFF_DATA;
	wire wr_a    = wr_i && addr_i == serial_usart_pkg::OFF_STAT_A;
	wire wr_b    = wr_i && addr_i == serial_usart_pkg::OFF_CTRL_B;
	wire wr_c    = wr_i && addr_i == serial_usart_pkg::OFF_FMT_C;
	wire wr_bh   = wr_i && addr_i == serial_usart_pkg::OFF_BAUD_H;
	wire wr_bl   = wr_i && addr_i == serial_usart_pkg::OFF_BAUD_L;
	wire rd_data = rd_i && addr_i == serial_usart_pkg::OFF_DATA;

	wire receiver_enable    = ctrl_b_r[serial_usart_pkg::B_RXEN];
	wire transmitter_enable = ctrl_b_r[serial_usart_pkg::B_TXEN];
	wire sync_mode_select   = fmt_c_r[serial_usart_pkg::C_SYNC];
	wire [1:0] parity_mode  = {fmt_c_r[serial_usart_pkg::C_PARH],
	                           fmt_c_r[serial_usart_pkg::C_PARL]};
	wire par_en             = parity_mode[1];
	wire stop_bits_select   = fmt_c_r[serial_usart_pkg::C_STOP2];
	wire clock_polarity     = fmt_c_r[serial_usart_pkg::C_POL];
	wire [3:0] nbits        = char_bits({ctrl_b_r[serial_usart_pkg::B_CSZH],
	                                     fmt_c_r[serial_usart_pkg::C_CSZ1],
	                                     fmt_c_r[serial_usart_pkg::C_CSZ0]});
	wire [8:0] bit_mask     = 9'h1ff >> (4'h9 - nbits);

	wire rx_complete_flag     = fifo_cnt_r != 2'h0;
	wire tx_buffer_empty_flag = !tbuf_v_r;
	wire [11:0] head          = rx_complete_flag ? fifo_r[0] : 12'h000;
	wire frame_error_flag     = head[11];
	wire parity_error_flag    = head[10];

	// ****************************************
	// Baud prescaler and bit timing
	// ****************************************
	wire tick = presc_r == 12'h000;
	// Asynchronous bits span 16 or 8 ticks; ignored in synchronous mode.
	wire [3:0] os_last = (double_speed_r && !sync_mode_select) ?
	                     serial_usart_pkg::OS_DOUBLE : serial_usart_pkg::OS_NORMAL;
	wire [3:0] os_half = (double_speed_r && !sync_mode_select) ?
	                     serial_usart_pkg::HALF_DOUBLE : serial_usart_pkg::HALF_NORMAL;
	wire sync_chg = sync_mode_select && tick && (xck_r == clock_polarity);
	wire sync_smp = sync_mode_select && tick && (xck_r != clock_polarity);

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			presc_r <= serial_usart_pkg::BAUD_RST;
			xck_r   <= 1'b0;
		end else if (ce_i) begin
			if (wr_bl)
				presc_r <= {baud_r[11:8], wdata_i};
			else
				presc_r <= tick ? baud_r : presc_r - 12'h001;
			if (tick && sync_mode_select)
				xck_r <= !xck_r;
		end
	end

	// ****************************************
	// Register writes and read data
	// ****************************************
	logic tx_done;
	wire  tx_load;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			ctrl_b_r           <= serial_usart_pkg::CTRL_B_RST;
			fmt_c_r            <= serial_usart_pkg::FMT_C_RST;
			baud_r             <= serial_usart_pkg::BAUD_RST;
			double_speed_r     <= 1'b0;
			multiproc_filter_r <= 1'b0;
			tx_complete_flag_r <= 1'b0;
			transmit_buffer_r  <= 9'h000;
			tbuf_v_r           <= 1'b0;
			rdata_o            <= 8'h00;
		end else if (ce_i) begin
			if (wr_a) begin
				double_speed_r     <= wdata_i[serial_usart_pkg::A_U2X];
				multiproc_filter_r <= wdata_i[serial_usart_pkg::A_MPCM];
			end
			if (wr_b)
				ctrl_b_r <= {wdata_i[7:2], 1'b0, wdata_i[0]};
			if (wr_c)
				fmt_c_r <= wdata_i[6:0];
			if (wr_bh)
				baud_r[11:8] <= wdata_i[3:0];
			if (wr_bl)
				baud_r[7:0] <= wdata_i;
			// A completing frame sets the flag even in the cycle it is cleared.
			if (tx_done && !tbuf_v_r)
				tx_complete_flag_r <= 1'b1;
			else if (tx_irq_ack_i || (wr_a && wdata_i[serial_usart_pkg::A_TXC]))
				tx_complete_flag_r <= 1'b0;
			if (wr_data && !tbuf_v_r) begin
				transmit_buffer_r <= {ctrl_b_r[serial_usart_pkg::B_TX8], wdata_i} & bit_mask;
				tbuf_v_r          <= 1'b1;
			end else if (tx_load)
				tbuf_v_r <= 1'b0;
			unique case (addr_i)
				serial_usart_pkg::OFF_DATA:   rdata_o <= head[7:0];
				serial_usart_pkg::OFF_STAT_A: rdata_o <= {rx_complete_flag, tx_complete_flag_r,
					tx_buffer_empty_flag, frame_error_flag, overrun_flag_r, parity_error_flag,
					double_speed_r, multiproc_filter_r};
				serial_usart_pkg::OFF_CTRL_B: rdata_o <= {ctrl_b_r[7:2], head[8], ctrl_b_r[0]};
				serial_usart_pkg::OFF_FMT_C:  rdata_o <= {1'b0, fmt_c_r};
				serial_usart_pkg::OFF_BAUD_H: rdata_o <= {4'h0, baud_r[11:8]};
				serial_usart_pkg::OFF_BAUD_L: rdata_o <= baud_r[7:0];
				default:                      rdata_o <= 8'h00;
			endcase
		end
	end

	assign rx_irq_o   = ctrl_b_r[serial_usart_pkg::B_RXCIE] && global_irq_enable_i
	                    && rx_complete_flag;
	assign tx_irq_o   = ctrl_b_r[serial_usart_pkg::B_TXCIE] && global_irq_enable_i
	                    && tx_complete_flag_r;
	assign udre_irq_o = ctrl_b_r[serial_usart_pkg::B_UDRIE] && global_irq_enable_i
	                    && tx_buffer_empty_flag;

	// ****************************************
	// Transmitter
	// ****************************************
	tx_state_t tx_st_r;
	logic [8:0] tx_sh_r;
	logic [3:0] tx_bit_r, tx_os_r;
	logic       tx_pin_r;

	wire tx_step = sync_mode_select ? sync_chg : (tick && tx_os_r == os_last);
	assign tx_load = tbuf_v_r && tx_owned_r && tx_st_r == TX_IDLE;
	assign tx_done = tx_step && ((tx_st_r == TX_STOP1 && !stop_bits_select)
	                 || tx_st_r == TX_STOP2);

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			tx_st_r    <= TX_IDLE;
			tx_sh_r    <= 9'h000;
			tx_bit_r   <= 4'h0;
			tx_os_r    <= 4'h0;
			tx_pin_r   <= 1'b1;
			tx_owned_r <= 1'b0;
		end else if (ce_i) begin
			// Disable only lands once nothing is left to send.
			if (transmitter_enable)
				tx_owned_r <= 1'b1;
			else if (!tbuf_v_r && tx_st_r == TX_IDLE)
				tx_owned_r <= 1'b0;
			tx_os_r <= (tx_load || tx_step) ? 4'h0 : (tick ? tx_os_r + 4'h1 : tx_os_r);
			if (tx_load) begin
				tx_sh_r  <= transmit_buffer_r;
				tx_st_r  <= TX_START;
				tx_pin_r <= 1'b0;
			end else if (tx_step) begin
				unique case (tx_st_r)
					TX_IDLE: tx_pin_r <= 1'b1;
					TX_START: begin
						tx_pin_r <= tx_sh_r[0];
						tx_bit_r <= 4'h1;
						tx_st_r  <= TX_DATA;
					end
					TX_DATA: begin
						if (tx_bit_r == nbits) begin
							tx_pin_r <= par_en ? par_of(tx_sh_r, parity_mode[0]) : 1'b1;
							tx_st_r  <= par_en ? TX_PAR : TX_STOP1;
						end else begin
							tx_pin_r <= tx_sh_r[tx_bit_r];
							tx_bit_r <= tx_bit_r + 4'h1;
						end
					end
					TX_PAR: begin
						tx_pin_r <= 1'b1;
						tx_st_r  <= TX_STOP1;
					end
					TX_STOP1: tx_st_r <= stop_bits_select ? TX_STOP2 : TX_IDLE;
					TX_STOP2: tx_st_r <= TX_IDLE;
				endcase
			end
		end
	end

	assign serial_out_pin_o = tx_pin_r;
	assign serial_out_en_o  = tx_owned_r;
	assign serial_clock_pin_o = xck_r;
	assign serial_clock_en_o  = sync_mode_select && (tx_owned_r || receiver_enable);
	assign rx_pin_owned_o   = receiver_enable;

	// ****************************************
	// Receiver and two-entry FIFO
	// ****************************************
	rx_state_t rx_st_r;
	logic [8:0] rx_sh_r;
	logic [3:0] rx_bit_r, rx_os_r;
	logic       rx_par_r;

	wire rx_in     = serial_in_pin_i;
	wire rx_idle   = rx_st_r == RX_IDLE;
	wire start_det = receiver_enable && rx_idle && !rx_in
	                 && (sync_mode_select ? sync_smp : tick);
	wire rx_smp    = !rx_idle && (sync_mode_select ? sync_smp : (tick
	                 && rx_os_r == (rx_st_r == RX_START ? os_half : os_last)));
	wire rx_done   = rx_smp && rx_st_r == RX_STOP;
	wire frame_type = (nbits == 4'h9) ? rx_sh_r[8] : rx_in;
	wire rx_accept = !(multiproc_filter_r && !frame_type);
	wire rx_pe     = par_en && (rx_par_r != par_of(rx_sh_r, parity_mode[0]));
	wire pop       = rd_data && rx_complete_flag;
	wire push      = wait_v_r && (fifo_cnt_r != 2'h2 || pop);
	wire [1:0] slot = fifo_cnt_r - {1'b0, pop};

	always_ff @(posedge clk_i) begin
		if (reset_i || !receiver_enable) begin
			// Reset and receiver disable both flush the buffer and errors.
			rx_st_r        <= RX_IDLE;
			rx_sh_r        <= 9'h000;
			rx_bit_r       <= 4'h0;
			rx_os_r        <= 4'h0;
			rx_par_r       <= 1'b0;
			fifo_cnt_r     <= 2'h0;
			wait_r         <= 12'h000;
			wait_v_r       <= 1'b0;
			overrun_flag_r <= 1'b0;
			fifo_r[0]      <= 12'h000;
			fifo_r[1]      <= 12'h000;
		end else if (ce_i) begin
			rx_os_r <= (start_det || rx_smp) ? 4'h0 : (tick ? rx_os_r + 4'h1 : rx_os_r);
			if (start_det) begin
				rx_sh_r  <= 9'h000;
				rx_bit_r <= 4'h0;
				rx_st_r  <= sync_mode_select ? RX_DATA : RX_START;
			end else if (rx_smp) begin
				unique case (rx_st_r)
					RX_START: rx_st_r <= rx_in ? RX_IDLE : RX_DATA;
					RX_DATA: begin
						rx_sh_r[rx_bit_r] <= rx_in;
						rx_bit_r <= rx_bit_r + 4'h1;
						if (rx_bit_r == nbits - 4'h1)
							rx_st_r <= par_en ? RX_PAR : RX_STOP;
					end
					RX_PAR: begin
						rx_par_r <= rx_in;
						rx_st_r  <= RX_STOP;
					end
					RX_STOP: rx_st_r <= RX_IDLE;
					default: rx_st_r <= RX_IDLE;
				endcase
			end
			// A new start while both levels and the waiting slot are full loses data.
			if (start_det && wait_v_r && fifo_cnt_r == 2'h2)
				overrun_flag_r <= 1'b1;
			else if (pop)
				overrun_flag_r <= 1'b0;
			if (rx_done && rx_accept) begin
				wait_r   <= {!rx_in, rx_pe, 1'b0, rx_sh_r};
				wait_v_r <= 1'b1;
			end else if (push)
				wait_v_r <= 1'b0;
			if (pop)
				fifo_r[0] <= fifo_r[1];
			if (push)
				fifo_r[slot[0]] <= wait_r;
			fifo_cnt_r <= fifo_cnt_r + {1'b0, push} - {1'b0, pop};
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	sequence s_busy_tx;
		tbuf_v_r || tx_st_r != TX_IDLE;
	endsequence

	a_udre_after_reset: assert property (@(posedge clk_i)
		$fell(reset_i) |-> tx_buffer_empty_flag)
		else $error("buffer empty flag low after reset");
	a_full_write_dropped: assert property (@(posedge clk_i) disable iff (reset_i)
		ce_i && wr_data && tbuf_v_r |=> $stable(transmit_buffer_r))
		else $error("write to full transmit buffer was taken");
	a_rx_disable_flush: assert property (@(posedge clk_i) disable iff (reset_i)
		!receiver_enable |=> !rx_complete_flag && !overrun_flag_r)
		else $error("receiver disable did not flush");
	a_read_pops_fifo: assert property (@(posedge clk_i) disable iff (reset_i)
		ce_i && rd_data && fifo_cnt_r == 2'h2 && !wait_v_r && receiver_enable
		|=> fifo_cnt_r == 2'h1)
		else $error("data read did not pop the receive FIFO");
	a_txc_sets: assert property (@(posedge clk_i) disable iff (reset_i)
		ce_i && tx_done && !tbuf_v_r |=> tx_complete_flag_r)
		else $error("transmit complete flag not set");
	a_irq_gating: assert property (@(posedge clk_i) disable iff (reset_i)
		rx_irq_o || tx_irq_o || udre_irq_o |-> global_irq_enable_i)
		else $error("interrupt raised without global enable");
	a_baud_reload: assert property (@(posedge clk_i) disable iff (reset_i)
		ce_i && wr_bl |=> presc_r == baud_r)
		else $error("low baud write did not reload prescaler");
	a_prescale_wrap: assert property (@(posedge clk_i) disable iff (reset_i)
		ce_i && tick && !wr_i ##1 ce_i |-> presc_r == baud_r)
		else $error("prescaler did not reload on wrap");
	a_tx_hold_pin: assert property (@(posedge clk_i) disable iff (reset_i)
		s_busy_tx and tx_owned_r |=> serial_out_en_o)
		else $error("transmitter released pin while busy");
	a_mp_filter_drop: assert property (@(posedge clk_i) disable iff (reset_i)
		ce_i && rx_done && multiproc_filter_r && !frame_type && !wait_v_r |=> !wait_v_r)
		else $error("data frame passed the multiprocessor filter");

endmodule : serial_usart

`default_nettype wire

/* serial_peer_model.sv */
// Remote serial transceiver that sends frames to the block and captures what it sends.
`timescale 1ns/1ps
`default_nettype none

module serial_peer_model (
	// Clock
	input  wire logic clk_i,
	// Line from the block
	input  wire logic line_from_dut_i,
	input  wire logic line_en_i,
	// Line to the block
	output logic      line_to_dut_o
);
	int unsigned bit_cycles = 16;
	int unsigned got_count  = 0;
	logic [11:0] got_bits   = 12'hfff;

	// The line idles at the mark level between frames.
	initial line_to_dut_o = 1'b1;

	task automatic put_bit(input logic v);
		@(posedge clk_i);
		line_to_dut_o <= v;
		repeat (bit_cycles - 1) @(posedge clk_i);
	endtask : put_bit

	// Start, data LSB first, parity when par[1] is set (par[0] picks odd), then one stop.
	// A zero stop is held only past mid-bit so its tail is not taken for a new start.
	task automatic send(input logic [8:0] d, input int nbits, input logic [1:0] par,
		input logic stop);
		logic p;
		p = par[0];
		put_bit(1'b0);
		for (int i = 0; i < nbits; i++) begin
			put_bit(d[i]);
			p ^= d[i];
		end
		if (par[1]) begin
			put_bit(p);
		end
		if (stop) begin
			put_bit(1'b1);
		end else begin
			@(posedge clk_i);
			line_to_dut_o <= 1'b0;
			repeat (bit_cycles / 2 + 1) @(posedge clk_i);
		end
		@(posedge clk_i);
		line_to_dut_o <= 1'b1;
	endtask : send

	// Twelve bit times are captured so that a second start inside the window shows up.
	initial begin
		forever begin
			@(negedge line_from_dut_i);
			if (line_en_i === 1'b1) begin
				repeat (bit_cycles / 2) @(posedge clk_i);
				for (int i = 0; i < 12; i++) begin
					repeat (bit_cycles) @(posedge clk_i);
					got_bits[i] = line_from_dut_i;
				end
				got_count++;
			end
		end
	end
endmodule : serial_peer_model
`default_nettype wire

/* tb_serial_usart_register_block.sv */
// Self-checking testbench of the serial transceiver against the remote peer model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin miscompares++; \
	$display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end

module tb_serial_usart_register_block;
	logic       clk_i;
	logic       reset_i;
	logic       ce_i;
	logic [2:0] addr_i;
	logic [7:0] wdata_i;
	logic       wr_i;
	logic       rd_i;
	logic [7:0] rdata_o;
	logic       global_irq_enable_i;
	logic       tx_irq_ack_i;
	logic       rx_irq_o;
	logic       tx_irq_o;
	logic       udre_irq_o;
	logic       serial_in_pin_i;
	logic       serial_out_pin_o;
	logic       serial_out_en_o;
	logic       rx_pin_owned_o;
	logic       serial_clock_pin_o;
	logic       serial_clock_en_o;
	logic       clk_seen;
	int         miscompares = 0;
	int         tests_run   = 0;
	int         cycles      = 0;
	int         frames      = 0;

	serial_usart u_dut (
		.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.global_irq_enable_i(global_irq_enable_i), .tx_irq_ack_i(tx_irq_ack_i),
		.rx_irq_o(rx_irq_o), .tx_irq_o(tx_irq_o), .udre_irq_o(udre_irq_o),
		.serial_in_pin_i(serial_in_pin_i), .serial_out_pin_o(serial_out_pin_o),
		.serial_out_en_o(serial_out_en_o), .rx_pin_owned_o(rx_pin_owned_o),
		.serial_clock_pin_o(serial_clock_pin_o), .serial_clock_en_o(serial_clock_en_o)
	);

	serial_peer_model peer (
		.clk_i(clk_i), .line_from_dut_i(serial_out_pin_o),
		.line_en_i(serial_out_en_o), .line_to_dut_o(serial_in_pin_i)
	);

	// ****************************************
	// Bus tasks
	// ****************************************
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clk_i);
		wr_i    <= 1'b0;
	endtask : wr

	task automatic rchk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clk_i);
		rd_i   <= 1'b0;
		@(negedge clk_i);
		`CHK(rdata_o & m, e)
	endtask : rchk

	task automatic wait_peer();
		frames++;
		for (int i = 0; i < 8000 && peer.got_count != frames; i++) @(posedge clk_i);
		`CHK(peer.got_count, frames)
	endtask : wait_peer

	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : wrap_up

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		@(negedge clk_i);
		`CHK(udre_irq_o, 1'b0)
		`CHK(serial_out_en_o, 1'b0)
		rchk(3'h1, 8'hff, 8'h20);
		rchk(3'h2, 8'hff, 8'h00);
		rchk(3'h3, 8'hff, 8'h06);
		rchk(3'h4, 8'hff, 8'h00);
		rchk(3'h5, 8'hff, 8'h00);
		rchk(3'h6, 8'hff, 8'h00);
		$display("reset values done");
	endtask : t_reset

	task automatic t_tx_basic();
		wr(3'h2, 8'h68);
		@(negedge clk_i);
		`CHK(udre_irq_o, 1'b1)
		// Second write lands while the buffer is still full and must be dropped.
		@(posedge clk_i);
		addr_i  <= 3'h0;
		wdata_i <= 8'ha5;
		wr_i    <= 1'b1;
		@(posedge clk_i);
		wdata_i <= 8'h3c;
		@(posedge clk_i);
		wr_i    <= 1'b0;
		@(negedge clk_i);
		`CHK(serial_out_en_o, 1'b1)
		wait_peer();
		`CHK(peer.got_bits, 12'hfa5)
		`CHK(tx_irq_o, 1'b1)
		rchk(3'h1, 8'hff, 8'h60);
		@(posedge clk_i);
		global_irq_enable_i <= 1'b0;
		@(negedge clk_i);
		`CHK(tx_irq_o, 1'b0)
		@(posedge clk_i);
		global_irq_enable_i <= 1'b1;
		wr(3'h1, 8'h40);
		rchk(3'h1, 8'hff, 8'h20);
		$display("transmit basic done");
	endtask : t_tx_basic

	task automatic t_tx_format();
		logic [7:0]  fmt [3] = '{8'h26, 8'h36, 8'h00};
		logic [7:0]  dat [3] = '{8'h03, 8'h03, 8'he0};
		logic [11:0] bits [3] = '{12'he03, 12'hf03, 12'hfe0};
		for (int i = 0; i < 3; i++) begin
			wr(3'h3, fmt[i]);
			wr(3'h0, dat[i]);
			wait_peer();
			`CHK(peer.got_bits, bits[i])
			@(posedge clk_i);
			tx_irq_ack_i <= 1'b1;
			@(posedge clk_i);
			tx_irq_ack_i <= 1'b0;
			@(negedge clk_i);
			`CHK(tx_irq_o, 1'b0)
		end
		wr(3'h3, 8'h06);
		wr(3'h0, 8'h5a);
		wr(3'h2, 8'h00);
		repeat (20) @(posedge clk_i);
		@(negedge clk_i);
		`CHK(serial_out_en_o, 1'b1)
		wait_peer();
		`CHK(peer.got_bits, 12'hf5a)
		@(negedge clk_i);
		`CHK(serial_out_en_o, 1'b0)
		$display("transmit format done");
	endtask : t_tx_format

	task automatic t_rx();
		wr(3'h2, 8'h90);
		@(negedge clk_i);
		`CHK(rx_pin_owned_o, 1'b1)
		peer.send(9'h03c, 8, 2'b00, 1'b1);
		peer.send(9'h05a, 8, 2'b00, 1'b1);
		repeat (4) @(posedge clk_i);
		`CHK(rx_irq_o, 1'b1)
		rchk(3'h1, 8'h80, 8'h80);
		rchk(3'h0, 8'hff, 8'h3c);
		rchk(3'h0, 8'hff, 8'h5a);
		rchk(3'h1, 8'h80, 8'h00);
		`CHK(rx_irq_o, 1'b0)
		wr(3'h3, 8'h00);
		peer.send(9'h0ff, 8, 2'b00, 1'b1);
		repeat (4) @(posedge clk_i);
		rchk(3'h0, 8'hff, 8'h1f);
		wr(3'h3, 8'h06);
		$display("receive basic done");
	endtask : t_rx

	task automatic t_rx_faults();
		peer.send(9'h011, 8, 2'b00, 1'b0);
		repeat (4) @(posedge clk_i);
		rchk(3'h1, 8'h1c, 8'h10);
		rchk(3'h0, 8'hff, 8'h11);
		rchk(3'h1, 8'h10, 8'h00);
		wr(3'h3, 8'h26);
		peer.send(9'h003, 8, 2'b11, 1'b1);
		peer.send(9'h003, 8, 2'b10, 1'b1);
		repeat (4) @(posedge clk_i);
		rchk(3'h1, 8'h04, 8'h04);
		rchk(3'h0, 8'hff, 8'h03);
		rchk(3'h1, 8'h04, 8'h00);
		rchk(3'h0, 8'hff, 8'h03);
		wr(3'h3, 8'h06);
		wr(3'h1, 8'h01);
		peer.send(9'h044, 8, 2'b00, 1'b0);
		peer.send(9'h055, 8, 2'b00, 1'b1);
		repeat (4) @(posedge clk_i);
		rchk(3'h0, 8'hff, 8'h55);
		rchk(3'h1, 8'h80, 8'h00);
		wr(3'h1, 8'h00);
		for (int i = 1; i < 5; i++) peer.send(9'(i), 8, 2'b00, 1'b1);
		repeat (4) @(posedge clk_i);
		rchk(3'h1, 8'h88, 8'h88);
		rchk(3'h0, 8'hff, 8'h01);
		wr(3'h2, 8'h00);
		rchk(3'h1, 8'h9c, 8'h00);
		$display("receive faults done");
	endtask : t_rx_faults

	task automatic t_rate();
		wr(3'h1, 8'h02);
		wr(3'h2, 8'h18);
		peer.bit_cycles = 8;
		wr(3'h0, 8'h96);
		wait_peer();
		`CHK(peer.got_bits, 12'hf96)
		peer.send(9'h0c3, 8, 2'b00, 1'b1);
		repeat (4) @(posedge clk_i);
		rchk(3'h0, 8'hff, 8'hc3);
		wr(3'h1, 8'h40);
		wr(3'h4, 8'h03);
		rchk(3'h4, 8'hff, 8'h03);
		wr(3'h4, 8'h00);
		wr(3'h5, 8'h01);
		rchk(3'h5, 8'hff, 8'h01);
		peer.bit_cycles = 32;
		wr(3'h0, 8'h69);
		wait_peer();
		`CHK(peer.got_bits, 12'hf69)
		// Nine-bit frames: the ninth bit is set up before the low byte moves.
		wr(3'h2, 8'h1c);
		wr(3'h0, 8'ha5);
		wait_peer();
		`CHK(peer.got_bits, 12'hea5)
		peer.send(9'h1c3, 9, 2'b00, 1'b1);
		repeat (4) @(posedge clk_i);
		rchk(3'h2, 8'h02, 8'h02);
		rchk(3'h0, 8'hff, 8'hc3);
		// Synchronous mode drives the serial clock, toggling on every rate tick.
		wr(3'h3, 8'h46);
		@(negedge clk_i);
		`CHK(serial_clock_en_o, 1'b1)
		clk_seen = serial_clock_pin_o;
		repeat (2) @(negedge clk_i);
		`CHK(serial_clock_pin_o, !clk_seen)
		wr(3'h3, 8'h06);
		@(negedge clk_i);
		`CHK(serial_clock_en_o, 1'b0)
		$display("rate done");
	endtask : t_rate

	// ****************************************
	// Clock, timeout and main sequence
	// ****************************************
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	// A full run needs well under half of this ceiling.
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			miscompares++;
			wrap_up();
		end
	end

	initial begin
		reset_i             = 1'b1;
		ce_i                = 1'b1;
		addr_i              = 3'h0;
		wdata_i             = 8'h00;
		wr_i                = 1'b0;
		rd_i                = 1'b0;
		global_irq_enable_i = 1'b1;
		tx_irq_ack_i        = 1'b0;
		repeat (5) @(posedge clk_i);
		reset_i <= 1'b0;
		t_reset();
		t_tx_basic();
		t_tx_format();
		t_rx();
		t_rx_faults();
		t_rate();
		wrap_up();
	end
endmodule : tb_serial_usart_register_block
`default_nettype wire
